// >>> include/pscl_pkg.sv
package pscl_pkg;
  // Clock and cycle arithmetic
  localparam int CLK_NS = 50;
  localparam int BYTE_W = 8;
  localparam int BIT_W = 3;
  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] pscl_cnt_t;
  // Least request low time, rounded up
  localparam int REQ_LOW_NS = 500;
  localparam int REQ_LOW_CYC = (REQ_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Least status low time during reset
  localparam int STATUS_LOW_US = 45;
  localparam int STATUS_LOW_CYC = (STATUS_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Host waits before first rising serial clock edge
  localparam int CF2CK_US = 230;
  localparam int CF2CK_CYC = (CF2CK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ST2CK_US = 2;
  localparam int ST2CK_CYC = (ST2CK_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Load complete to user mode, internal oscillator start-up
  localparam int CD2UM_US = 300;
  localparam int CD2UM_CYC = (CD2UM_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Startup clock enable delay: 4 periods at the fastest serial clock
  localparam int CD2CU_NS = 30;
  localparam int CD2CU_CYC_RAW = (CD2CU_NS + CLK_NS - 1) / CLK_NS;
  localparam int CD2CU_CYC = (CD2CU_CYC_RAW < 1) ? 1 : CD2CU_CYC_RAW;
  // Startup clock periods before user mode
  localparam int USR_PERIODS = 3192;
  // Falling edges needed after load complete
  localparam int FALL_EDGES = 2;
  // Host wait for load complete after the last bit
  localparam int TAIL_WAIT_CYC = 16;
  // Plain defaults, not taken from any part
  localparam int POR_CYC_DEF = 2000;
  localparam int NBYTES_DEF = 16;
endpackage

// >>> include/pscl_if.sv
`timescale 1ns/1ps
interface pscl_if;
  logic serial_config_clock; // Host-made link clock
  logic data0; // Serial configuration data
  logic config_request_n; // Configuration request, low starts
  logic status_oe; // Device pulls status low
  logic load_complete; // Bitstream accepted
  wire config_status_n = ~status_oe; // Open drain with pull-up
  modport device (
    input serial_config_clock, data0, config_request_n, config_status_n,
    output status_oe, load_complete
  );
  modport host (
    output serial_config_clock, data0, config_request_n,
    input config_status_n, load_complete
  );
endinterface // pscl_if

// >>> rtl/pscl_sync.sv
`timescale 1ns/1ps
module pscl_sync #(
  parameter int W = 1 // Number of bits
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Sync reset, active high
  input wire logic [W-1:0] d, // Foreign levels
  output logic [W-1:0] q // Settled levels
);
  logic [W-1:0] meta; // First stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // Next values
  always_comb begin
    next_meta = rst ? '0 : d;
    next_q = rst ? '0 : meta;
  end

  // Two flops per bit
  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule // pscl_sync

// >>> rtl/pscl_device.sv
`timescale 1ns/1ps
module pscl_device #(
  parameter int POR_CYC = pscl_pkg::POR_CYC_DEF, // Power-on hold length
  parameter int UM_CYC = pscl_pkg::CD2UM_CYC, // Oscillator start-up length
  parameter int NBYTES = pscl_pkg::NBYTES_DEF // Bitstream length in bytes
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Sync reset, active high
  input wire logic use_user_clk, // Startup clock option strap
  input wire logic user_startup_clock, // Startup clock pin
  pscl_if.device link, // Configuration pins
  output logic [pscl_pkg::BYTE_W-1:0] rx_byte, // Received byte
  output logic rx_valid, // One pulse per byte
  output logic user_mode // Running user logic
);
  import pscl_pkg::*;

  typedef enum logic [3:0] {
    S_POR = 4'h0,
    S_CLEAR = 4'h1,
    S_REL = 4'h2,
    S_RX = 4'h3,
    S_INIT = 4'h4,
    S_CU = 4'h5,
    S_USRCK = 4'h6,
    S_OSC = 4'h7,
    S_USER = 4'h8
  } pscl_dev_e;

  // Link side state, cleared while no load is open
  logic link_clr; // From mclk flop, async clear of link logic
  logic [BIT_W-1:0] bit_cnt, next_bit_cnt; // Bit in byte
  logic [BYTE_W-1:0] sreg, next_sreg; // Shift register
  logic [BYTE_W-1:0] byte_q, next_byte_q; // Held for the crossing
  logic tog, next_tog; // Flips once per byte
  logic done, next_done; // Whole bitstream seen
  pscl_cnt_t nrx, next_nrx; // Bytes seen
  logic [1:0] falls, next_falls; // Falling edges after done
  logic go, next_go; // Initialization may start

  // Shift in on rising edges until the stream is complete
  always_comb begin
    next_sreg = sreg;
    next_bit_cnt = bit_cnt;
    next_byte_q = byte_q;
    next_tog = tog;
    next_nrx = nrx;
    next_done = done;
    if (!done) begin
      next_sreg = {link.data0, sreg[BYTE_W-1:1]};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == BIT_W'(BYTE_W - 1)) begin
        next_byte_q = next_sreg;
        next_tog = ~tog;
        next_nrx = nrx + 16'h0001;
        next_done = (nrx == pscl_cnt_t'(NBYTES - 1));
      end
    end
  end

  // Link clock stops between loads, so the clear is asynchronous
  always_ff @(posedge link.serial_config_clock or posedge link_clr) begin
    if (link_clr) begin
      sreg <= 8'h00;
      bit_cnt <= 3'h0;
      byte_q <= 8'h00;
      tog <= 1'b0;
      nrx <= 16'h0000;
      done <= 1'b0;
    end else begin
      sreg <= next_sreg;
      bit_cnt <= next_bit_cnt;
      byte_q <= next_byte_q;
      tog <= next_tog;
      nrx <= next_nrx;
      done <= next_done;
    end
  end

  // Count falling edges once the stream is complete
  always_comb begin
    next_falls = falls;
    next_go = go;
    if (done && !go) begin
      next_falls = falls + 2'h1;
      next_go = (falls == 2'(FALL_EDGES - 1));
    end
  end

  // Falling edge process
  always_ff @(negedge link.serial_config_clock or posedge link_clr) begin
    if (link_clr) begin
      falls <= 2'h0;
      go <= 1'b0;
    end else begin
      falls <= next_falls;
      go <= next_go;
    end
  end

  // Pins and link levels into the system clock domain
  logic req_s, stat_s, usr_s, done_s, go_s, tog_s, use_s;
  pscl_sync #(.W(7)) u_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d({link.config_request_n, link.config_status_n, user_startup_clock,
        done, go, tog, use_user_clk}),
    .q({req_s, stat_s, usr_s, done_s, go_s, tog_s, use_s})
  );

  // Sequencer state
  pscl_dev_e state, next_state;
  pscl_cnt_t cnt, next_cnt; // Interval counter
  logic status_oe, next_status_oe; // Pulling status low
  logic load_r, next_load; // Load complete level
  logic next_link_clr;
  logic tog_q, next_tog_q; // Last toggle seen
  logic usr_q, next_usr_q; // Last startup clock level
  logic [BYTE_W-1:0] next_rx_byte;
  logic next_rx_valid, next_user_mode;

  assign link.status_oe = status_oe;
  assign link.load_complete = load_r;

  // Reset handshake, byte hand-over and start-up sequence
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_status_oe = status_oe;
    next_load = load_r;
    next_link_clr = link_clr;
    next_user_mode = user_mode;
    next_tog_q = tog_s;
    next_usr_q = usr_s;
    next_rx_byte = rx_byte;
    next_rx_valid = 1'b0;
    // Byte is stable on the link side once its toggle is seen
    if ((state == S_RX || state == S_INIT) && tog_s != tog_q) begin
      next_rx_byte = byte_q;
      next_rx_valid = 1'b1;
    end
    unique case (state)
      S_POR: begin
        next_cnt = cnt + 16'h0001;
        if (cnt >= pscl_cnt_t'(POR_CYC - 1)) begin
          next_state = S_REL;
          next_status_oe = 1'b0;
        end
      end
      S_CLEAR: begin
        // Counter saturates; the low time is the longer of both
        if (cnt < pscl_cnt_t'(STATUS_LOW_CYC - 1)) begin
          next_cnt = cnt + 16'h0001;
        end else if (req_s) begin
          next_state = S_REL;
          next_status_oe = 1'b0;
        end
      end
      S_REL: begin
        // Wait out any external hold on status
        if (stat_s) begin
          next_state = S_RX;
          next_link_clr = 1'b0;
        end
      end
      S_RX: begin
        if (done_s) begin
          next_state = S_INIT;
          next_load = 1'b1;
        end
      end
      S_INIT: begin
        next_cnt = 16'h0000;
        if (go_s) begin
          next_state = use_s ? S_CU : S_OSC;
        end
      end
      S_CU: begin
        next_cnt = cnt + 16'h0001;
        if (cnt >= pscl_cnt_t'(CD2CU_CYC - 1)) begin
          next_state = S_USRCK;
          next_cnt = 16'h0000;
        end
      end
      S_USRCK: begin
        // Startup clock must run below a quarter of mclk
        if (usr_s && !usr_q) begin
          next_cnt = cnt + 16'h0001;
          if (cnt == pscl_cnt_t'(USR_PERIODS - 1)) begin
            next_state = S_USER;
            next_user_mode = 1'b1;
          end
        end
      end
      S_OSC: begin
        next_cnt = cnt + 16'h0001;
        if (cnt >= pscl_cnt_t'(UM_CYC - 1)) begin
          next_state = S_USER;
          next_user_mode = 1'b1;
        end
      end
      S_USER: begin
        next_status_oe = 1'b0;
        next_load = 1'b1;
      end
      default: begin
        next_state = S_CLEAR;
      end
    endcase
    // A low request restarts from any state other than S_POR and S_CLEAR
    if (!req_s && state != S_POR && state != S_CLEAR) begin
      next_state = S_CLEAR;
      next_cnt = 16'h0000;
      next_status_oe = 1'b1;
      next_load = 1'b0;
      next_link_clr = 1'b1;
      next_user_mode = 1'b0;
      next_rx_valid = 1'b0;
    end
  end

  // Register the sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= S_POR;
      cnt <= 16'h0000;
      status_oe <= 1'b1;
      load_r <= 1'b0;
      link_clr <= 1'b1;
      user_mode <= 1'b0;
      tog_q <= 1'b0;
      usr_q <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      status_oe <= next_status_oe;
      load_r <= next_load;
      link_clr <= next_link_clr;
      user_mode <= next_user_mode;
      tog_q <= next_tog_q;
      usr_q <= next_usr_q;
      rx_byte <= next_rx_byte;
      rx_valid <= next_rx_valid;
    end
  end
endmodule // pscl_device

// >>> rtl/pscl_host.sv
`timescale 1ns/1ps
module pscl_host #(
  parameter int CF2CK = pscl_pkg::CF2CK_CYC, // Wait after request high
  parameter int NBYTES = pscl_pkg::NBYTES_DEF // Bitstream length in bytes
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Sync reset, active high
  input wire logic start, // Begin a configuration
  input wire logic [pscl_pkg::BYTE_W-1:0] tx_byte, // Next bitstream byte
  input wire logic tx_valid, // Byte offered
  output logic tx_ready, // Byte may be taken
  output logic busy, // Configuration in progress
  output logic cfg_ok, // Last load accepted
  output logic cfg_fail, // A load was retried
  pscl_if.host link // Configuration pins
);
  import pscl_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_REQ = 3'h1,
    H_WST = 3'h2,
    H_WCK = 3'h3,
    H_LOAD = 3'h4,
    H_SHIFT = 3'h5,
    H_TAIL = 3'h6,
    H_EDGE = 3'h7
  } pscl_host_e;

  // Status and load complete are foreign levels
  logic st_s, ld_s;
  pscl_sync #(.W(2)) u_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d({link.config_status_n, link.load_complete}),
    .q({st_s, ld_s})
  );

  pscl_host_e state, next_state;
  pscl_cnt_t cnt, next_cnt; // Short interval counter
  pscl_cnt_t cf_cnt, next_cf_cnt; // Time since request high
  pscl_cnt_t nbyte, next_nbyte; // Bytes sent
  logic [BYTE_W-1:0] sh, next_sh; // Byte being sent
  logic [BIT_W-1:0] bit_i, next_bit_i; // Bit index
  logic ph, next_ph; // Low or high half of a bit
  logic ck, next_ck; // Serial clock, mclk divided by two
  logic dat, next_dat; // Serial data
  logic req_n, next_req_n; // Request line
  logic next_tx_ready, next_busy, next_ok, next_fail;

  assign link.serial_config_clock = ck;
  assign link.data0 = dat;
  assign link.config_request_n = req_n;

  // Sequencing of the whole load; every wait counts mclk cycles
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cf_cnt = cf_cnt;
    next_nbyte = nbyte;
    next_sh = sh;
    next_bit_i = bit_i;
    next_ph = ph;
    next_ck = ck;
    next_dat = dat;
    next_req_n = req_n;
    next_tx_ready = tx_ready;
    next_busy = busy;
    next_ok = cfg_ok;
    next_fail = cfg_fail;
    unique case (state)
      H_IDLE: begin
        next_ck = 1'b0;
        next_dat = 1'b0;
        if (start) begin
          next_state = H_REQ;
          next_req_n = 1'b0;
          next_cnt = 16'h0000;
          next_busy = 1'b1;
          next_ok = 1'b0;
          next_fail = 1'b0;
        end
      end
      H_REQ: begin
        next_cnt = cnt + 16'h0001;
        if (cnt >= pscl_cnt_t'(REQ_LOW_CYC - 1)) begin
          next_state = H_WST;
          next_req_n = 1'b1;
          next_cf_cnt = 16'h0000;
        end
      end
      H_WST: begin
        if (cf_cnt != 16'hffff) next_cf_cnt = cf_cnt + 16'h0001;
        if (st_s) begin
          next_state = H_WCK;
          next_cnt = 16'h0000;
        end
      end
      H_WCK: begin
        if (cf_cnt != 16'hffff) next_cf_cnt = cf_cnt + 16'h0001;
        if (cnt != 16'hffff) next_cnt = cnt + 16'h0001;
        // Both waits must have passed before the first rising edge
        if (cf_cnt >= pscl_cnt_t'(CF2CK - 1) &&
            cnt >= pscl_cnt_t'(ST2CK_CYC - 1)) begin
          next_state = H_LOAD;
          next_tx_ready = 1'b1;
          next_nbyte = 16'h0000;
        end
      end
      H_LOAD: begin
        if (tx_valid) begin
          next_state = H_SHIFT;
          next_sh = tx_byte;
          next_tx_ready = 1'b0;
          next_bit_i = 3'h0;
          next_ph = 1'b0;
        end
      end
      H_SHIFT: begin
        next_ph = ~ph;
        if (!ph) begin
          next_ck = 1'b0;
          next_dat = sh[bit_i];
        end else begin
          next_ck = 1'b1;
          next_bit_i = bit_i + 3'h1;
          if (bit_i == BIT_W'(BYTE_W - 1)) begin
            next_nbyte = nbyte + 16'h0001;
            next_cnt = 16'h0000;
            if (nbyte == pscl_cnt_t'(NBYTES - 1)) begin
              next_state = H_TAIL;
            end else begin
              next_state = H_LOAD;
              next_tx_ready = 1'b1;
            end
          end
        end
      end
      H_TAIL: begin
        next_cnt = cnt + 16'h0001;
        if (ld_s) begin
          next_state = H_EDGE;
          next_cnt = 16'h0000;
        end else if (cnt >= pscl_cnt_t'(TAIL_WAIT_CYC - 1)) begin
          next_state = H_REQ;
          next_req_n = 1'b0;
          next_cnt = 16'h0000;
          next_fail = 1'b1;
        end
      end
      H_EDGE: begin
        // Fall, rise, fall: two falling edges
        next_cnt = cnt + 16'h0001;
        next_ck = cnt[0];
        if (cnt == 16'h0002) begin
          next_state = H_IDLE;
          next_busy = 1'b0;
          next_ok = 1'b1;
          next_dat = 1'b0;
        end
      end
    endcase
    // Status dropping mid-load is an error: restart
    if (!st_s && (state == H_WCK || state == H_LOAD || state == H_SHIFT)) begin
      next_state = H_REQ;
      next_req_n = 1'b0;
      next_cnt = 16'h0000;
      next_ck = 1'b0;
      next_tx_ready = 1'b0;
      next_fail = 1'b1;
    end
  end

  // Register the sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= H_IDLE;
      cnt <= 16'h0000;
      cf_cnt <= 16'h0000;
      nbyte <= 16'h0000;
      sh <= 8'h00;
      bit_i <= 3'h0;
      ph <= 1'b0;
      ck <= 1'b0;
      dat <= 1'b0;
      req_n <= 1'b1;
      tx_ready <= 1'b0;
      busy <= 1'b0;
      cfg_ok <= 1'b0;
      cfg_fail <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cf_cnt <= next_cf_cnt;
      nbyte <= next_nbyte;
      sh <= next_sh;
      bit_i <= next_bit_i;
      ph <= next_ph;
      ck <= next_ck;
      dat <= next_dat;
      req_n <= next_req_n;
      tx_ready <= next_tx_ready;
      busy <= next_busy;
      cfg_ok <= next_ok;
      cfg_fail <= next_fail;
    end
  end
endmodule // pscl_host

// >>> tb/pscl_checker.sv
`timescale 1ns/1ps
// Watches the link between the host and device ends
module pscl_checker #(
  parameter int CF2CK = pscl_pkg::CF2CK_CYC // Host wait after request high
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Sync reset, active high
  input wire logic serial_config_clock, // Link clock
  input wire logic data0, // Serial data
  input wire logic config_request_n, // Request, active low
  input wire logic status_oe, // Device pulls status low
  input wire logic config_status_n, // Status wire
  input wire logic load_complete // Bitstream accepted
);
  import pscl_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Run stays far below int range, so no saturation
  int low_cnt; // Request low samples
  int req_cnt; // Request high samples
  int ok_cnt; // Status released samples
  int run_cnt; // Status pulled samples
  int hold_cnt; // Status held after request high
  int ld_cnt; // Load complete samples
  logic run_req; // Status pulse began with a request
  int next_low_cnt, next_req_cnt, next_ok_cnt, next_run_cnt, next_hold_cnt, next_ld_cnt;
  logic next_run_req;
  // Next counts from the link levels
  always_comb begin
    next_low_cnt = config_request_n ? 0 : low_cnt + 1;
    next_req_cnt = config_request_n ? req_cnt + 1 : 0;
    next_ok_cnt = status_oe ? 0 : ok_cnt + 1;
    next_run_cnt = status_oe ? run_cnt + 1 : 0;
    next_hold_cnt = (status_oe && config_request_n) ? hold_cnt + 1 : 0;
    next_ld_cnt = load_complete ? ld_cnt + 1 : 0;
    next_run_req = status_oe && (run_req || !config_request_n);
  end
  // Clear in reset; the power-on pulse carries no request flag
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {low_cnt, req_cnt, ok_cnt, run_cnt, hold_cnt, ld_cnt} <= '0;
      run_req <= 1'h0;
    end else begin
      {low_cnt, req_cnt, ok_cnt} <= {next_low_cnt, next_req_cnt, next_ok_cnt};
      {run_cnt, hold_cnt, ld_cnt} <= {next_run_cnt, next_hold_cnt, next_ld_cnt};
      run_req <= next_run_req;
    end
  end
  req_low_len_a: assert property ($rose(config_request_n) |->
    low_cnt >= REQ_LOW_CYC) else $error("request low pulse too short");
  stat_follows_a: assert property (!config_request_n [*5] |-> !config_status_n)
    else $error("status not pulled during request");
  ld_drop_req_a: assert property (!config_request_n [*5] |-> !load_complete)
    else $error("load complete high during request");
  stat_run_len_a: assert property ($fell(status_oe) && run_req |->
    run_cnt >= STATUS_LOW_CYC && run_cnt <= CF2CK_CYC) else $error("status pulse length");
  stat_release_a: assert property (hold_cnt <= CF2CK_CYC)
    else $error("status held too long after request");
  ck_after_req_a: assert property ($rose(serial_config_clock) |->
    config_request_n && req_cnt >= CF2CK) else $error("link clock too soon after request");
  ck_after_stat_a: assert property ($rose(serial_config_clock) |->
    config_status_n && ok_cnt >= ST2CK_CYC) else $error("link clock too soon after status");
  ld_holds_a: assert property (load_complete && config_request_n |=> load_complete)
    else $error("load complete dropped without request");
  ld_needs_stat_a: assert property ($rose(load_complete) |->
    config_status_n && config_request_n) else $error("load complete during reset");
  lines_quiet_a: assert property (ld_cnt >= TAIL_WAIT_CYC |->
    $stable(serial_config_clock) && $stable(data0)) else $error("link lines moving in user mode");
  cover property ($rose(load_complete));
  cover property ($fell(config_request_n) && load_complete);
  cover property ($fell(status_oe) && run_req);
endmodule // pscl_checker

// >>> tb/test_passive_serial_config_timing.sv
`timescale 1ns/1ps
module test_passive_serial_config_timing;
  import pscl_pkg::*;
  // Shortened counts keep the run brief
  localparam int POR = 20;
  localparam int UM = 50;
  // Longer than the status pulse, so the request wait is what gates the clock
  localparam int CFK = 1000;
  localparam int NB = 8;
  logic mclk = 1'h0; // System clock
  logic sys_rst = 1'h1; // Sync reset
  logic use_user_clk = 1'h0; // Startup clock strap
  logic user_startup_clock = 1'h0; // Startup clock
  logic start = 1'h0; // Begin a load
  logic [BYTE_W-1:0] tx_byte = '0; // Offered byte
  logic tx_valid = 1'h0; // Byte offered
  logic tx_ready, busy, cfg_ok, cfg_fail, rx_valid, user_mode, fail_b; // Design outputs
  logic [BYTE_W-1:0] rx_byte; // Received byte
  logic [BYTE_W-1:0] rx_q[$]; // Notes for the device side
  logic [BYTE_W-1:0] wire_q[$]; // Notes for the wire
  logic [BYTE_W-1:0] sr = '0; // Wire shift register
  logic [31:0] rng = 32'h000143a7; // Xorshift state
  int fails = 0;
  int checks_done = 0;
  int nbit = 0; // Bits seen on the wire
  int falls = 0; // Falls after load complete
  int usr_edges = 0; // Startup clock edges
  realtime ck_rise = 0.0; // Last link clock rise
  pscl_if link();
  pscl_if link_b();
  // Second pair: host stream shorter than device wants, so loads never finish
  pscl_device #(.POR_CYC(POR), .UM_CYC(UM), .NBYTES(NB)) i_pscl_device (
    .mclk(mclk), .sys_rst(sys_rst), .use_user_clk(use_user_clk),
    .user_startup_clock(user_startup_clock), .link(link.device), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .user_mode(user_mode));
  pscl_host #(.CF2CK(CFK), .NBYTES(NB)) i_pscl_host (
    .mclk(mclk), .sys_rst(sys_rst), .start(start), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .busy(busy), .cfg_ok(cfg_ok), .cfg_fail(cfg_fail), .link(link.host));
  pscl_device #(.POR_CYC(POR), .UM_CYC(UM), .NBYTES(4)) i_pscl_device_b (
    .mclk(mclk), .sys_rst(sys_rst), .use_user_clk(1'h0),
    .user_startup_clock(user_startup_clock), .link(link_b.device), .rx_byte(),
    .rx_valid(), .user_mode());
  pscl_host #(.CF2CK(CFK), .NBYTES(2)) i_pscl_host_b (
    .mclk(mclk), .sys_rst(sys_rst), .start(start), .tx_byte(tx_byte), .tx_valid(1'h1),
    .tx_ready(), .busy(), .cfg_ok(), .cfg_fail(fail_b), .link(link_b.host));
  pscl_checker #(.CF2CK(CFK)) i_pscl_checker (
    .mclk(mclk), .sys_rst(sys_rst), .serial_config_clock(link.serial_config_clock),
    .data0(link.data0), .config_request_n(link.config_request_n), .status_oe(link.status_oe),
    .config_status_n(link.config_status_n), .load_complete(link.load_complete));
  // System clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Startup clock, slower than a quarter of mclk for its synchroniser
  initial begin
    #7.3;
    forever #115 user_startup_clock = ~user_startup_clock;
  end
  always @(posedge user_startup_clock) usr_edges++;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Always takes one edge, so a level is judged at a sampling edge
  task automatic wait_for(ref logic sig, input int lim, input string what);
    int n;
    n = 0;
    @(posedge mclk);
    while (sig !== 1'h1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (sig !== 1'h1) begin
      check({"timeout on ", what}, 1, sig);
      end_of_test();
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // One whole load, then the start-up into user mode
  task automatic load(input logic strap);
    int n;
    @(posedge mclk);
    #2 use_user_clk = strap;
    start = 1'h1;
    nbit = 0;
    falls = 0;
    @(posedge mclk);
    #2 start = 1'h0;
    for (int i = 0; i < NB; i++) begin
      @(posedge mclk);
      #2 rng = xs(rng);
      tx_byte = rng[BYTE_W-1:0];
      tx_valid = 1'h1;
      rx_q.push_back(rng[BYTE_W-1:0]);
      wire_q.push_back(rng[BYTE_W-1:0]);
      wait_for(tx_ready, 5000, "tx_ready");
      #2 tx_valid = 1'h0;
      check("busy in load", 1, busy);
    end
    wait_for(cfg_ok, 200, "cfg_ok");
    check("busy after load", 0, busy);
    usr_edges = 0;
    n = 0;
    while (user_mode !== 1'h1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    // A start-up that never ends is a mismatch and closes the run
    if (user_mode !== 1'h1) begin
      check("timeout on user_mode", 1, user_mode);
      end_of_test();
    end
    if (strap) begin
      check("startup edges", 1,
            usr_edges >= USR_PERIODS - 1 && usr_edges <= USR_PERIODS + 2);
    end else begin
      check("user mode delay", 1, n >= UM - 2 && n <= UM + 8);
    end
    check("user pins", 3'h7,
          {link.config_request_n, link.config_status_n, link.load_complete});
    check("falls after load", FALL_EDGES, falls);
    check("main retry flag", 0, cfg_fail);
    // Every offered byte must have come out on both sides
    check("rx notes left", 0, rx_q.size());
    check("wire notes left", 0, wire_q.size());
  endtask
  // Device side results against the notes
  always @(posedge mclk) begin
    if (rx_valid === 1'h1) begin
      check("rx byte", rx_q.size() > 0 ? {24'h0, rx_q.pop_front()} : 32'hxxxxxxxx,
            {24'h0, rx_byte});
    end
  end
  // Wire order: bits rebuilt least significant first
  always @(posedge link.serial_config_clock) begin
    // Rise to rise no shorter than the slowest part's limit
    check("link clock period", 1, $realtime - ck_rise >= 1000.0 / 66);
    ck_rise = $realtime;
    if (link.config_request_n === 1'h1 && link.load_complete !== 1'h1) begin
      sr = {link.data0, sr[BYTE_W-1:1]};
      nbit++;
      if (nbit % BYTE_W == 0) begin
        check("wire byte", wire_q.size() > 0 ? {24'h0, wire_q.pop_front()} : 32'hxxxxxxxx,
              {24'h0, sr});
      end
    end
  end
  always @(negedge link.serial_config_clock) begin
    if (link.load_complete === 1'h1) falls++;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    #2 sys_rst = 1'h0;
    repeat (POR - 2) @(posedge mclk);
    check("status in power-on", 0, link.config_status_n);
    check("load complete idle", 0, link.load_complete);
    repeat (8) @(posedge mclk);
    check("status after power-on", 1, link.config_status_n);
    load(1'h0);
    wait_for(fail_b, 4000, "short stream retry");
    load(1'h1);
    end_of_test();
  end
endmodule // test_passive_serial_config_timing
